// ### hw/sltc_regs.vh
/*
  Register map, field positions, reset values and timing codes for the
  sensor link timing configuration block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SLTC_REGS_VH
`define SLTC_REGS_VH

// ==========================================================
// Register indices and byte addresses (index times four)
`define SLTC_IDX_TIMING 8'h22
`define SLTC_IDX_SYMPER 8'h23
`define SLTC_IDX_BDIAG 8'h24
`define SLTC_IDX_MODE 8'h40
`define SLTC_IDX_STATUS 8'h41
`define SLTC_ADDR_TIMING 12'h088
`define SLTC_ADDR_SYMPER 12'h08c
`define SLTC_ADDR_BDIAG 12'h090
`define SLTC_ADDR_MODE 12'h100
`define SLTC_ADDR_STATUS 12'h104

// ==========================================================
// Field positions
`define SLTC_TRAIN_EN_BIT 0
`define SLTC_TRAIN_RST_BIT 3
`define SLTC_SS_EN_BIT 4
`define SLTC_FRAG_BIT 1
`define SLTC_BGD_EN_BIT 0

// ==========================================================
// Reset values
`define SLTC_TIMING_RST 8'h00
`define SLTC_SYMPER_RST 8'h00
`define SLTC_BDIAG_RST 8'h00
`define SLTC_MODE_RST 2'h0
`define SLTC_OSC_DEFAULT 8'h80

// ==========================================================
// Operating modes held in the mode register
`define SLTC_MODE_DSI3 2'h0
`define SLTC_MODE_PSI5 2'h1
`define SLTC_MODE_PSI5_DIAG 2'h2

// ==========================================================
// Symbol timing outputs, in units of 0.1 us
`define SLTC_PSI5_FAST_BIT 8'h35
`define SLTC_PSI5_SLOW_BIT 8'h50

// ==========================================================
// DSI3 chip times per symbol period code, in units of 0.1 us
`define SLTC_CHIP_T0 8'h0a
`define SLTC_CHIP_T1 8'h14
`define SLTC_CHIP_T2 8'h19
`define SLTC_CHIP_T3 8'h1a
`define SLTC_CHIP_T4 8'h1a
`define SLTC_CHIP_T5 8'h1b
`define SLTC_CHIP_T6 8'h1c
`define SLTC_CHIP_T7 8'h1d
`define SLTC_CHIP_T8 8'h1e
`define SLTC_CHIP_T9 8'h1f
`define SLTC_CHIP_T10 8'h20
`define SLTC_CHIP_T11 8'h21
`define SLTC_CHIP_T12 8'h23
`define SLTC_CHIP_T13 8'h28
`define SLTC_CHIP_T14 8'h2d
`define SLTC_CHIP_T15 8'h32

// ==========================================================
// Diagnostic fragment sizes per sampling period
`define SLTC_FRAG_CMD_SHORT 3'h2
`define SLTC_FRAG_CMD_LONG 3'h4
`define SLTC_FRAG_RSP_SHORT 3'h3
`define SLTC_FRAG_RSP_LONG 3'h6

`endif

// ### hw/sltc_top.v
/*
  Sensor link timing configuration: APB register bank holding the
  oscillator training controls, symbol period and background diagnostic
  configuration, with decoded timing outputs and parity check.
  Assumes a 20 MHz CLK, APB master on the same clock, and a training
  source that delivers trimmed oscillator values in the same domain.
*/
// Function
// - Training enable set: oscillator follows bus-derived trim, ignoring restore.
// - Enable and restore both clear: hold the last trained oscillator value.
// - Enable clear, restore set: oscillator returns to factory default value.
// - Training only from PSI5 timing; no training with enable cleared.
// - Chip/bit time register at 0x23, reset zero, latency select and code fields.
// - Both configuration registers covered by register array error detection.
// - Chip/bit time register accessible only in PSI5 diagnostic mode.
// - Latency select 0 times to slot, 1 times to sync pulse.
// - PSI5 code top bit 0 gives 5.3 us, 1 gives 8.0 us, slew on.
// - DSI3 periodic chip time from code table; slew off for codes 0, 1.
// - Background diagnostic register at 0x24, reset zero, fragment and enable.
// - Background diagnostic register accessible in DSI3 or PSI5 diagnostic mode.
// - Fragment size 0: 2 bits, 3 chips; 1: 4 bits, 6 chips.
// - Background diagnostic enable turns background diagnostic mode off or on.
`timescale 1ns/10ps
`include "sltc_regs.vh"

module sltc_top (
  input wire CLK, // 20 MHz clock
  input wire RST_N, // Async reset, active low
  input wire PSEL, // APB select
  input wire PENABLE, // APB access phase
  input wire PWRITE, // APB direction
  input wire [11:0] PADDR, // APB byte address
  input wire [31:0] PWDATA, // APB write data
  output reg [31:0] PRDATA, // APB read data
  output reg PREADY, // APB ready
  output reg PSLVERR, // APB error
  input wire TRAIN_VALID, // Trimmed value available
  input wire [7:0] TRAIN_VALUE, // Trimmed oscillator value
  output reg [7:0] OSC_TRIM, // Oscillator trim applied
  output reg SS_EN, // Latency relative to sync pulse
  output reg [7:0] PSI5_BIT_TIME, // PSI5 bit period, 0.1 us units
  output reg PSI5_SLEW_EN, // PSI5 slew control
  output reg [7:0] DSI3_CHIP_TIME, // DSI3 chip time, 0.1 us units
  output reg DSI3_SLEW_EN, // DSI3 slew control
  output reg BGD_ACTIVE, // Background diagnostic mode on
  output reg [2:0] FRAG_CMD_BITS, // Command bits per period
  output reg [2:0] FRAG_RSP_CHIPS, // Response chips per period
  output reg PARITY_ERR // Register array parity error
);

  // ==========================================================
  // Functions
  function [7:0] chip_time_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: chip_time_of = `SLTC_CHIP_T0;
        4'h1: chip_time_of = `SLTC_CHIP_T1;
        4'h2: chip_time_of = `SLTC_CHIP_T2;
        4'h3: chip_time_of = `SLTC_CHIP_T3;
        4'h4: chip_time_of = `SLTC_CHIP_T4;
        4'h5: chip_time_of = `SLTC_CHIP_T5;
        4'h6: chip_time_of = `SLTC_CHIP_T6;
        4'h7: chip_time_of = `SLTC_CHIP_T7;
        4'h8: chip_time_of = `SLTC_CHIP_T8;
        4'h9: chip_time_of = `SLTC_CHIP_T9;
        4'ha: chip_time_of = `SLTC_CHIP_T10;
        4'hb: chip_time_of = `SLTC_CHIP_T11;
        4'hc: chip_time_of = `SLTC_CHIP_T12;
        4'hd: chip_time_of = `SLTC_CHIP_T13;
        4'he: chip_time_of = `SLTC_CHIP_T14;
        default: chip_time_of = `SLTC_CHIP_T15;
      endcase
    end
  endfunction

  function even_par;
    input [7:0] v;
    begin
      even_par = ^v;
    end
  endfunction

  function [2:0] frag_cmd_of;
    input long;
    begin
      frag_cmd_of = long ? `SLTC_FRAG_CMD_LONG : `SLTC_FRAG_CMD_SHORT;
    end
  endfunction

  function [2:0] frag_rsp_of;
    input long;
    begin
      frag_rsp_of = long ? `SLTC_FRAG_RSP_LONG : `SLTC_FRAG_RSP_SHORT;
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] timing_ff;
  reg [7:0] symper_ff;
  reg [7:0] bdiag_ff;
  reg [1:0] mode_ff;
  reg par_timing_ff;
  reg par_chip_ff;
  reg par_bdiag_ff;
  reg [7:0] trained_ff;

  wire setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire is_diag = (mode_ff == `SLTC_MODE_PSI5_DIAG);
  wire is_dsi3 = (mode_ff == `SLTC_MODE_DSI3);
  wire is_psi5 = (mode_ff == `SLTC_MODE_PSI5) | is_diag;
  wire chip_ok = is_diag;
  wire bdiag_ok = is_dsi3 | is_diag;
  wire train_en = timing_ff[`SLTC_TRAIN_EN_BIT];
  wire train_rst = timing_ff[`SLTC_TRAIN_RST_BIT];

  reg addr_ok;
  reg [7:0] rd_val;
  reg [7:0] nxt_timing;
  reg [7:0] nxt_symper;
  reg [7:0] nxt_bdiag;
  reg [1:0] nxt_mode;
  reg [7:0] nxt_trained;
  reg [7:0] nxt_osc_trim;
  reg nxt_ss_en;
  reg [7:0] nxt_bit_time;
  reg [7:0] nxt_chip_time;
  reg nxt_dsi3_slew;
  reg nxt_bgd_active;
  reg [2:0] nxt_frag_cmd;
  reg [2:0] nxt_frag_rsp;
  reg nxt_parity_err;

  // ==========================================================
  // Address decode and write enables
  always @* begin
    addr_ok = 1'b1;
    rd_val = 8'h00;
    nxt_timing = timing_ff;
    nxt_symper = symper_ff;
    nxt_bdiag = bdiag_ff;
    nxt_mode = mode_ff;
    case (PADDR)
      `SLTC_ADDR_TIMING: begin
        rd_val = timing_ff;
        if (wr & bdiag_ok) begin
          nxt_timing = PWDATA[7:0];
        end
      end
      `SLTC_ADDR_SYMPER: begin
        rd_val = chip_ok ? symper_ff : 8'h00;
        if (wr & chip_ok) begin
          nxt_symper = PWDATA[7:0];
        end
      end
      `SLTC_ADDR_BDIAG: begin
        rd_val = bdiag_ok ? bdiag_ff : 8'h00;
        if (wr & bdiag_ok) begin
          nxt_bdiag = PWDATA[7:0];
        end
      end
      `SLTC_ADDR_MODE: begin
        rd_val = {6'h00, mode_ff};
        if (wr) begin
          nxt_mode = PWDATA[1:0];
        end
      end
      `SLTC_ADDR_STATUS: begin
        rd_val = {7'h00, PARITY_ERR};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Register file with parity, one wait state free APB answer
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      timing_ff <= `SLTC_TIMING_RST;
      symper_ff <= `SLTC_SYMPER_RST;
      bdiag_ff <= `SLTC_BDIAG_RST;
      mode_ff <= `SLTC_MODE_RST;
      par_timing_ff <= 1'b0;
      par_chip_ff <= 1'b0;
      par_bdiag_ff <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      timing_ff <= nxt_timing;
      symper_ff <= nxt_symper;
      bdiag_ff <= nxt_bdiag;
      mode_ff <= nxt_mode;
      par_timing_ff <= even_par(nxt_timing);
      par_chip_ff <= even_par(nxt_symper);
      par_bdiag_ff <= even_par(nxt_bdiag);
      // Ready registered from setup so the access phase ends in one cycle
      PREADY <= setup;
      PSLVERR <= setup & ~addr_ok;
      if (setup & ~PWRITE) begin
        PRDATA <= {24'h000000, rd_val};
      end
    end
  end

  // ==========================================================
  // Oscillator trim, next state
  always @* begin
    nxt_trained = trained_ff;
    nxt_osc_trim = OSC_TRIM;
    if (train_en) begin
      // Only PSI5 traffic may drive training
      if (TRAIN_VALID & is_psi5) begin
        nxt_trained = TRAIN_VALUE;
        nxt_osc_trim = TRAIN_VALUE;
      end
    end else if (train_rst) begin
      // Trained value kept so a later clear of restore brings it back
      nxt_osc_trim = `SLTC_OSC_DEFAULT;
    end else begin
      nxt_osc_trim = trained_ff;
    end
  end

  // ==========================================================
  // Oscillator trim registers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trained_ff <= `SLTC_OSC_DEFAULT;
      OSC_TRIM <= `SLTC_OSC_DEFAULT;
    end else begin
      trained_ff <= nxt_trained;
      OSC_TRIM <= nxt_osc_trim;
    end
  end

  // ==========================================================
  // Decoded timing and diagnostic outputs, next state
  always @* begin
    nxt_ss_en = symper_ff[`SLTC_SS_EN_BIT];
    nxt_bit_time = symper_ff[3] ? `SLTC_PSI5_SLOW_BIT : `SLTC_PSI5_FAST_BIT;
    nxt_chip_time = chip_time_of(symper_ff[3:0]);
    // Two fastest chip times run without slew shaping
    nxt_dsi3_slew = (symper_ff[3:1] != 3'h0);
    nxt_bgd_active = bdiag_ff[`SLTC_BGD_EN_BIT];
    nxt_frag_cmd = frag_cmd_of(bdiag_ff[`SLTC_FRAG_BIT]);
    nxt_frag_rsp = frag_rsp_of(bdiag_ff[`SLTC_FRAG_BIT]);
    // Sticky until reset; a flipped bit in the timing, chip/bit time or diagnostic register flags
    nxt_parity_err = PARITY_ERR | (even_par(timing_ff) != par_timing_ff)
      | (even_par(symper_ff) != par_chip_ff)
      | (even_par(bdiag_ff) != par_bdiag_ff);
  end

  // ==========================================================
  // Decoded timing and diagnostic output registers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SS_EN <= 1'b0;
      PSI5_BIT_TIME <= `SLTC_PSI5_FAST_BIT;
      PSI5_SLEW_EN <= 1'b1;
      DSI3_CHIP_TIME <= `SLTC_CHIP_T0;
      DSI3_SLEW_EN <= 1'b0;
      BGD_ACTIVE <= 1'b0;
      FRAG_CMD_BITS <= `SLTC_FRAG_CMD_SHORT;
      FRAG_RSP_CHIPS <= `SLTC_FRAG_RSP_SHORT;
      PARITY_ERR <= 1'b0;
    end else begin
      SS_EN <= nxt_ss_en;
      PSI5_BIT_TIME <= nxt_bit_time;
      PSI5_SLEW_EN <= 1'b1;
      DSI3_CHIP_TIME <= nxt_chip_time;
      DSI3_SLEW_EN <= nxt_dsi3_slew;
      BGD_ACTIVE <= nxt_bgd_active;
      FRAG_CMD_BITS <= nxt_frag_cmd;
      FRAG_RSP_CHIPS <= nxt_frag_rsp;
      PARITY_ERR <= nxt_parity_err;
    end
  end

endmodule // sltc_top

// ### verification/sltc_props.sv
/* Port checker for sltc_top.
   Assumes the bind below and one clock domain. */
`timescale 1ns/10ps
module sltc_props (
  input wire CLK, // clock
  input wire RST_N, // reset
  input wire PSEL, // select
  input wire PENABLE, // access
  input wire PREADY, // ready
  input wire PSLVERR, // error
  input wire TRAIN_VALID, // trim valid
  input wire [7:0] TRAIN_VALUE, // trim value
  input wire [7:0] OSC_TRIM, // trim out
  input wire [7:0] PSI5_BIT_TIME, // bit time
  input wire PSI5_SLEW_EN, // slew
  input wire [7:0] DSI3_CHIP_TIME, // chip time
  input wire DSI3_SLEW_EN, // slew
  input wire [2:0] FRAG_CMD_BITS, // cmd bits
  input wire [2:0] FRAG_RSP_CHIPS, // rsp chips
  input wire PARITY_ERR // parity
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========
  // Bus, decode, trim and parity
  property p_rdy; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_pslew; PSI5_SLEW_EN; endproperty
  a_pslew: assert property (p_pslew) else $error("psi5 slew off");
  property p_bit; PSI5_BIT_TIME == 8'h35 || PSI5_BIT_TIME == 8'h50; endproperty
  a_bit: assert property (p_bit) else $error("psi5 bit time");
  property p_dslew; DSI3_SLEW_EN == (DSI3_CHIP_TIME > 8'h14); endproperty
  a_dslew: assert property (p_dslew) else $error("dsi3 slew");
  property p_frag; FRAG_CMD_BITS == 3'h2 ? FRAG_RSP_CHIPS == 3'h3 : FRAG_RSP_CHIPS == 3'h6;
  endproperty
  a_frag: assert property (p_frag) else $error("fragment pair");
  property p_trim;
    $changed(OSC_TRIM) |-> OSC_TRIM == 8'h80 || ($past(TRAIN_VALID) && OSC_TRIM == $past(TRAIN_VALUE));
  endproperty
  a_trim: assert property (p_trim) else $error("trim change");
  property p_par; !PARITY_ERR; endproperty
  a_par: assert property (p_par) else $error("parity error");
endmodule // sltc_props
bind sltc_top sltc_props u_props (.*);

// ### verification/sltc_trainer.sv
/* Training source partner: one trim pulse per kick.
   Assumes the bench clock. */
`timescale 1ns/10ps
module sltc_trainer (
  input wire CLK, // clock
  input wire kick, // request
  input wire [7:0] val, // value
  output logic TRAIN_VALID, // pulse
  output logic [7:0] TRAIN_VALUE // trim
);
  initial TRAIN_VALID = 1'b0;
  initial TRAIN_VALUE = 8'h00;
  // Idle value toggles so stale data never looks valid
  always @(posedge CLK) begin
    TRAIN_VALID <= kick;
    TRAIN_VALUE <= kick ? val : ~TRAIN_VALUE;
  end
endmodule // sltc_trainer

// ### verification/tb.sv
/* Bench for sltc_top: APB driver, queue monitor, training partner.
   Assumes sltc_regs.vh on the include path. */
`timescale 1ns/10ps
`include "sltc_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, kick = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0;
  logic [7:0] tv = 0, d, v;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, TRAIN_VALID, SS_EN, PSI5_SLEW_EN, DSI3_SLEW_EN, BGD_ACTIVE, PARITY_ERR;
  wire [7:0] TRAIN_VALUE, OSC_TRIM, PSI5_BIT_TIME, DSI3_CHIP_TIME;
  wire [2:0] FRAG_CMD_BITS, FRAG_RSP_CHIPS;
  integer errors = 0, compares = 0, seed = 65, i;
  logic [33:0] q[$];
  logic [7:0] ct [16] = '{8'h0a, 8'h14, 8'h19, 8'h1a, 8'h1a, 8'h1b, 8'h1c, 8'h1d,
    8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23, 8'h28, 8'h2d, 8'h32};
  always #25 CLK = ~CLK;
  sltc_top u_dut (.*);
  sltc_trainer u_trn (.CLK(CLK), .kick(kick), .val(tv), .TRAIN_VALID(TRAIN_VALID),
    .TRAIN_VALUE(TRAIN_VALUE));
  task finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // Bus master
  task apb(input bit w, input [11:0] a, input [7:0] wd, input [7:0] e, input bit er);
    integer k;
    begin
      k = 0;
      PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= {24'h0, wd};
      q.push_back({~w, er, 24'h0, e});
      @(posedge CLK);
      PENABLE <= 1;
      do begin @(posedge CLK); k++; end while (PREADY !== 1'b1 && k < 20);
      if (k >= 20) begin errors++; finish_test; end
      PSEL <= 0; PENABLE <= 0;
      @(posedge CLK);
    end
  endtask
  always @(posedge CLK) if (PREADY === 1'b1) begin
    `CHK("pslverr", q[0][32], PSLVERR)
    if (q[0][33]) `CHK("prdata", q[0][31:0], PRDATA)
    void'(q.pop_front());
  end
  task train(input [7:0] tval);
    kick <= 1; tv <= tval;
    @(posedge CLK);
    kick <= 0;
    repeat (3) @(posedge CLK);
  endtask
  initial begin repeat (20000) @(posedge CLK); errors++; finish_test; end
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    `CHK("osc", 8'h80, OSC_TRIM)
    apb(0, `SLTC_ADDR_BDIAG, 0, 8'h00, 0);
    apb(1, `SLTC_ADDR_SYMPER, 8'h1f, 0, 0);
    apb(1, `SLTC_ADDR_MODE, 8'h02, 0, 0);
    apb(0, `SLTC_ADDR_SYMPER, 0, 8'h00, 0);
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      d[3:0] = i[3:0];
      apb(1, `SLTC_ADDR_SYMPER, d, 0, 0);
      apb(0, `SLTC_ADDR_SYMPER, 0, d, 0);
      `CHK("pslew", 1'b1, PSI5_SLEW_EN)
      `CHK("chip", ct[i], DSI3_CHIP_TIME)
      `CHK("dslew", 1'(i > 1), DSI3_SLEW_EN)
      `CHK("bit", d[3] ? 8'h50 : 8'h35, PSI5_BIT_TIME)
      `CHK("ss", d[4], SS_EN)
    end
    for (i = 0; i < 4; i++) begin
      apb(1, `SLTC_ADDR_BDIAG, i[7:0], 0, 0);
      apb(0, `SLTC_ADDR_BDIAG, 0, i[7:0], 0);
      `CHK("bgd", i[0], BGD_ACTIVE)
      `CHK("cmd", i[1] ? 3'h4 : 3'h2, FRAG_CMD_BITS)
      `CHK("rsp", i[1] ? 3'h6 : 3'h3, FRAG_RSP_CHIPS)
    end
    v = $random(seed);
    apb(1, `SLTC_ADDR_TIMING, 8'h09, 0, 0);
    train(v);
    `CHK("trim", v, OSC_TRIM)
    apb(1, `SLTC_ADDR_TIMING, 8'h00, 0, 0);
    train(~v);
    `CHK("trim", v, OSC_TRIM)
    apb(1, `SLTC_ADDR_TIMING, 8'h08, 0, 0);
    // Trim follows the stored restore bit one clock later
    repeat (2) @(posedge CLK);
    `CHK("trim", 8'h80, OSC_TRIM)
    apb(1, `SLTC_ADDR_MODE, 8'h00, 0, 0);
    apb(1, `SLTC_ADDR_TIMING, 8'h01, 0, 0);
    train(v);
    `CHK("trim", 8'h80, OSC_TRIM)
    apb(1, `SLTC_ADDR_MODE, 8'h01, 0, 0);
    apb(1, `SLTC_ADDR_BDIAG, 8'h01, 0, 0);
    apb(1, `SLTC_ADDR_MODE, 8'h00, 0, 0);
    apb(0, `SLTC_ADDR_BDIAG, 0, 8'h03, 0);
    apb(1, `SLTC_ADDR_MODE, 8'h03, 0, 0);
    apb(1, `SLTC_ADDR_BDIAG, 8'h00, 0, 0);
    apb(0, `SLTC_ADDR_TIMING, 0, 8'h01, 0);
    apb(1, `SLTC_ADDR_MODE, 8'h00, 0, 0);
    apb(0, `SLTC_ADDR_BDIAG, 0, 8'h03, 0);
    apb(1, 12'h200, 8'h55, 0, 1);
    apb(0, `SLTC_ADDR_STATUS, 0, 8'h00, 0);
    finish_test;
  end
endmodule // tb
